//--- design/nbs_pkg.sv
// Purpose: shared constants for the non-blocking flash system-call sequencer
// Assumes: one clock CORE_CLK at 125 MHz, synchronous active-low reset
// Notes: both ends import this package
// How it works
// - program-row: key2 DB, row 31:16, opcode 0008
// - resume: key2 DC, opcode 0009 with request
// - argument holds SRAM address; key1 B6 there
// - resume ignores parameter bits 31:16
// - program row runs exactly one phase
// - caller resumes once after program row
// - caller resumes thrice after write row
// - each resume starts the next phase, or ends the call after the last
// - only resume accepted while phases outstanding
// - caller loads page latch before programming
// - caller issues requests only from SRAM
// - SRAM access never stalled during phase
// - status word overwrites argument; success 0xA
// - interrupt after every completed phase
// - non-resume while pending returns F0000008
// - resume during running phase returns F0000009
package nbs_pkg;
  localparam logic [7:0] KEY1 = 8'hB6;
  localparam logic [7:0] KEY2_WRITE = 8'hDA;
  localparam logic [7:0] KEY2_PROG = 8'hDB;
  localparam logic [7:0] KEY2_RESUME = 8'hDC;
  localparam logic [15:0] OP_WRITE_ROW = 16'h0007;
  localparam logic [15:0] OP_PROG_ROW = 16'h0008;
  localparam logic [15:0] OP_RESUME = 16'h0009;
  localparam int REQ_BIT = 31;
  localparam logic [31:0] ST_OK = 32'hA000_0000;
  localparam logic [31:0] ST_RESUME_DONE = 32'hF000_0007;
  localparam logic [31:0] ST_PENDING = 32'hF000_0008;
  localparam logic [31:0] ST_BUSY = 32'hF000_0009;
  localparam logic [31:0] ST_BAD_OP = 32'hF000_000B;
  localparam logic [31:0] ST_KEY_MISMATCH = 32'hF000_000C;
  localparam logic [1:0] PHASES_WRITE = 2'h3;
  localparam logic [1:0] PHASES_PROG = 2'h1;
  localparam int PHASE_CYCLES = 64;
  // host-side software registers
  localparam logic [3:0] HA_CMD = 4'h0;
  localparam logic [3:0] HA_PARAM = 4'h1;
  localparam logic [3:0] HA_STATUS = 4'h2;
  localparam logic [3:0] HA_IRQ_STAT = 4'h3;
  localparam logic [3:0] HA_IRQ_MASK = 4'h4;
  localparam logic [3:0] HA_RESULT = 4'h5;
  localparam logic [31:0] SRAM_PARAM_ADDR = 32'h2000_0000;
endpackage

//--- design/nbs_if.sv
`timescale 1ns/10ps
// Purpose: link between processor end and sequencer end
// Assumes: single clock domain
// Notes: register writes take one cycle; reads return next cycle
interface nbs_if;
  logic arg_we;
  logic req_we;
  logic arg_re;
  logic [31:0] wdata;
  logic [31:0] arg_rdata;
  logic [31:0] param_addr;
  logic [31:0] param_data;
  logic busy;
  logic phase_irq;
  modport device (input arg_we, req_we, arg_re, wdata, param_data,
    output arg_rdata, param_addr, busy, phase_irq);
  modport host (output arg_we, req_we, arg_re, wdata, param_data,
    input arg_rdata, param_addr, busy, phase_irq);
endinterface

//--- design/nbs_device.sv
// Chosen here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/10ps
// Purpose: sequencer end: decodes calls, runs phases, writes status
// Assumes: parameter word answered combinationally at param_addr
// Notes: flash array timing modelled by a phase counter
module nbs_device #(
  parameter int PHASE_LEN = nbs_pkg::PHASE_CYCLES
) (
  // system
  input wire logic CORE_CLK,
  input wire logic NRST,
  // link
  nbs_if.device LNK,
  // flash array view
  output logic [15:0] ROW_ID,
  output logic [1:0] PHASE_NUM,
  output logic PHASE_ACTIVE
);
  import nbs_pkg::*;
  // the phase counter is 16 bits wide and needs at least two states
  if (PHASE_LEN < 2 || PHASE_LEN > 65535) begin : g_len_check
    $error("PHASE_LEN out of range");
  end
  typedef enum logic [2:0] {
    S_IDLE = 3'b001, S_RUN = 3'b010, S_WAIT = 3'b100
  } nbs_dev_e;
  typedef struct packed {
    nbs_dev_e st;
    logic [31:0] arg;
    logic [15:0] row;
    logic [1:0] left;
    logic [1:0] num;
    logic [15:0] cnt;
    logic irq;
  } nbs_dev_s;
  nbs_dev_s r_q, r_d;
  logic [31:0] pw;
  logic cmd;
  logic [15:0] op;
  logic keys_ok;
  assign pw = LNK.param_data;
  assign cmd = LNK.req_we && LNK.wdata[REQ_BIT];
  assign op = LNK.wdata[15:0];
  always_comb begin
    r_d = r_q;
    r_d.irq = 1'b0;
    keys_ok = 1'b0;
    if (r_q.st == S_RUN) begin
      if (r_q.cnt == 16'(PHASE_LEN - 1)) begin
        r_d.cnt = 16'h0000;
        r_d.irq = 1'b1;
        r_d.left = r_q.left - 2'h1;
        r_d.st = S_WAIT;
      end else begin
        r_d.cnt = r_q.cnt + 16'h0001;
      end
    end
    if (LNK.arg_we && r_q.st == S_IDLE) begin
      r_d.arg = LNK.wdata;
    end
    if (cmd) begin
      unique case (op)
        OP_RESUME: begin
          keys_ok = pw[7:0] == KEY1 && pw[15:8] == KEY2_RESUME;
          if (!keys_ok) begin
            r_d.arg = ST_KEY_MISMATCH;
          end else if (r_q.st == S_RUN) begin
            r_d.arg = ST_BUSY;
          end else if (r_q.st == S_IDLE) begin
            r_d.arg = ST_RESUME_DONE;
          end else begin
            r_d.arg = ST_OK;
            if (r_q.left != 2'h0) begin
              r_d.st = S_RUN;
              r_d.num = r_q.num + 2'h1;
            end else begin
              r_d.st = S_IDLE;
            end
          end
        end
        OP_WRITE_ROW, OP_PROG_ROW: begin
          keys_ok = pw[7:0] == KEY1
            && pw[15:8] == ((op == OP_PROG_ROW) ? KEY2_PROG : KEY2_WRITE);
          if (r_q.st != S_IDLE) begin
            r_d.arg = ST_PENDING;
          end else if (!keys_ok) begin
            r_d.arg = ST_KEY_MISMATCH;
          end else begin
            r_d.arg = ST_OK;
            r_d.row = pw[31:16];
            r_d.left = (op == OP_PROG_ROW) ? PHASES_PROG : PHASES_WRITE;
            r_d.num = 2'h0;
            r_d.cnt = 16'h0000;
            r_d.st = S_RUN;
          end
        end
        default: begin
          r_d.arg = (r_q.st != S_IDLE) ? ST_PENDING : ST_BAD_OP;
        end
      endcase
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      r_q <= '{st: S_IDLE, arg: 32'h0000_0000, row: 16'h0000, left: 2'h0,
        num: 2'h0, cnt: 16'h0000, irq: 1'b0};
    end else begin
      r_q <= r_d;
    end
  end
  // sram path is never gated by the phase engine
  assign LNK.param_addr = r_q.arg;
  assign LNK.arg_rdata = r_q.arg;
  assign LNK.busy = r_q.st != S_IDLE;
  assign LNK.phase_irq = r_q.irq;
  assign ROW_ID = r_q.row;
  assign PHASE_NUM = r_q.num;
  assign PHASE_ACTIVE = r_q.st == S_RUN;
endmodule

//--- design/nbs_host.sv
`timescale 1ns/10ps
// Purpose: processor end: issues a non-blocking call and its resumes
// Assumes: page latch already loaded and code runs from SRAM
// Notes: resumes fire from the phase interrupt, so no resume can be early
module nbs_host (
  // system
  input wire logic CORE_CLK,
  input wire logic NRST,
  // software port
  input wire logic [3:0] ADDR,
  input wire logic [31:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [31:0] RDATA,
  output logic IRQ,
  // link
  nbs_if.host LNK
);
  import nbs_pkg::*;
  typedef enum logic [3:0] {
    H_IDLE = 4'b0001, H_ARG = 4'b0010, H_REQ = 4'b0100, H_WAIT = 4'b1000
  } nbs_host_e;
  typedef struct packed {
    nbs_host_e st;
    logic res;
    logic prog;
    logic [15:0] row;
    logic [1:0] need;
    logic [31:0] result;
    logic [1:0] stat;
    logic [1:0] mask;
    logic [31:0] rdata;
  } nbs_host_s;
  nbs_host_s r_q, r_d;
  always_comb begin
    r_d = r_q;
    r_d.rdata = 32'h0000_0000;
    if (WR && ADDR == HA_PARAM) begin
      r_d.row = WDATA[31:16];
    end
    if (WR && ADDR == HA_IRQ_MASK) begin
      r_d.mask = WDATA[1:0];
    end
    if (WR && ADDR == HA_CMD && r_q.st == H_IDLE) begin
      r_d.prog = WDATA[0];
      r_d.need = WDATA[0] ? PHASES_PROG : PHASES_WRITE;
      r_d.res = 1'b0;
      r_d.st = H_ARG; // page latch loaded beforehand by software
    end
    unique case (r_q.st)
      H_IDLE: ;
      H_ARG: r_d.st = H_REQ;
      H_REQ: r_d.st = H_WAIT;
      H_WAIT: begin
        if (LNK.phase_irq) begin
          r_d.need = r_q.need - 2'h1;
          r_d.res = 1'b1;
          r_d.st = H_ARG;
        end else if (!LNK.busy) begin
          r_d.result = LNK.arg_rdata;
          r_d.stat[0] = 1'b1;
          r_d.st = H_IDLE;
        end
      end
      default: r_d.st = H_IDLE;
    endcase
    if (RD) begin
      unique case (ADDR)
        HA_STATUS: r_d.rdata = {28'h0000000, r_q.need, r_q.prog, r_q.st != H_IDLE};
        HA_IRQ_STAT: r_d.rdata = {30'h0, r_q.stat};
        HA_IRQ_MASK: r_d.rdata = {30'h0, r_q.mask};
        HA_RESULT: r_d.rdata = r_q.result;
        HA_PARAM: r_d.rdata = {r_q.row, 16'h0000};
        default: r_d.rdata = 32'h0000_0000;
      endcase
      if (ADDR == HA_IRQ_STAT) begin
        r_d.stat = 2'b00;
      end
    end
    // a set in the same cycle as the clearing read wins
    if (r_q.st == H_WAIT && LNK.phase_irq) begin
      r_d.stat[1] = 1'b1;
    end
    if (r_q.st == H_WAIT && !LNK.phase_irq && !LNK.busy) begin
      r_d.stat[0] = 1'b1;
    end
  end
  always_ff @(posedge CORE_CLK) begin
    if (!NRST) begin
      r_q <= '{st: H_IDLE, res: 1'b0, prog: 1'b0, row: 16'h0000, need: 2'h0,
        result: 32'h0000_0000, stat: 2'b00, mask: 2'b00, rdata: 32'h0000_0000};
    end else begin
      r_q <= r_d;
    end
  end
  assign LNK.arg_we = r_q.st == H_ARG;
  assign LNK.req_we = r_q.st == H_REQ;
  assign LNK.arg_re = 1'b0;
  assign LNK.wdata = (r_q.st == H_ARG) ? SRAM_PARAM_ADDR
    : {16'h8000, r_q.res ? OP_RESUME : (r_q.prog ? OP_PROG_ROW : OP_WRITE_ROW)};
  // parameter word built from host registers whatever param_addr holds
  assign LNK.param_data = r_q.res ? {16'h0000, KEY2_RESUME, KEY1}
    : {r_q.row, r_q.prog ? KEY2_PROG : KEY2_WRITE, KEY1};
  assign RDATA = r_q.rdata;
  assign IRQ = |(r_q.stat & r_q.mask);
endmodule

//--- tb/nbs_asserts.sv
// Purpose: link checks between host end and device end
// Assumes: one clock, NRST low resets
// Notes: age_q counts cycles since the last request
`timescale 1ns/10ps
module nbs_asserts #(parameter int PHASE_LEN = 64) (
  // system
  input wire logic CORE_CLK,
  input wire logic NRST,
  // link
  input wire logic arg_we,
  input wire logic req_we,
  input wire logic [31:0] wdata,
  input wire logic [31:0] arg_rdata,
  input wire logic [31:0] param_data,
  input wire logic busy,
  input wire logic phase_irq
);
  import nbs_pkg::*;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);
  logic [15:0] age_q;
  // saturates so a long idle spell cannot wrap into a false match
  always_ff @(posedge CORE_CLK) age_q <= req_we ? 16'h1 : age_q + 16'(age_q != 16'hFFFF);
  sequence s_prog_go;
    req_we && wdata[REQ_BIT] && !busy && wdata[15:0] == OP_PROG_ROW
      && param_data[15:0] == {KEY2_PROG, KEY1};
  endsequence
  sequence s_ok;
    busy && arg_rdata == ST_OK;
  endsequence
  property p_start; s_prog_go |=> s_ok; endproperty
  a_start: assert property (p_start) else $error("start not accepted");
  property p_pend; req_we && busy && wdata[15:0] != OP_RESUME |=> arg_rdata == ST_PENDING;
  endproperty
  a_pend: assert property (p_pend) else $error("call while pending");
  // age_q already reads 1 in the cycle after the request edge
  property p_len; phase_irq |-> age_q == 16'(PHASE_LEN + 1); endproperty
  a_len: assert property (p_len) else $error("phase length wrong");
  property p_pulse; phase_irq |=> !phase_irq; endproperty
  a_pulse: assert property (p_pulse) else $error("phase irq too long");
  property p_irq_busy; phase_irq |-> busy; endproperty
  a_irq_busy: assert property (p_irq_busy) else $error("irq while idle");
  property p_done;
    $fell(busy) |-> $past(req_we) && $past(wdata[15:0]) == OP_RESUME && arg_rdata == ST_OK;
  endproperty
  a_done: assert property (p_done) else $error("end without resume");
  property p_hold; !arg_we && !req_we |=> $stable(arg_rdata); endproperty
  a_hold: assert property (p_hold) else $error("status moved");
  property p_arg_busy; busy && arg_we |=> $stable(arg_rdata); endproperty
  a_arg_busy: assert property (p_arg_busy) else $error("arg taken while busy");
endmodule

//--- tb/nonblocking_flash_syscall_seq_tb.sv
// Purpose: bench for both link ends and a hand-driven second link
// Assumes: phase length shortened to 8
// Notes: the second link reaches refusals the host never makes
`timescale 1ns/10ps
module nonblocking_flash_syscall_seq_tb;
  import nbs_pkg::*;
  localparam int PL = 8;
  logic CORE_CLK = 1'b0;
  logic NRST = 1'b0;
  logic [3:0] ADDR = 4'h0;
  logic [31:0] WDATA = 32'h0;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic [31:0] RDATA;
  logic IRQ;
  logic [15:0] ROW_ID;
  logic [15:0] row_b;
  logic [1:0] phase_num;
  logic [1:0] num_b;
  logic act_b;
  int errors = 0;
  int compares = 0;
  int irqs = 0;
  nbs_if lnk();
  nbs_if lnk_b();
  nbs_host i_nbs_host (.CORE_CLK(CORE_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IRQ(IRQ), .LNK(lnk));
  nbs_device #(.PHASE_LEN(PL)) i_nbs_device (.CORE_CLK(CORE_CLK), .NRST(NRST), .LNK(lnk),
    .ROW_ID(ROW_ID), .PHASE_NUM(phase_num), .PHASE_ACTIVE());
  nbs_device #(.PHASE_LEN(PL)) i_nbs_device_b (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .LNK(lnk_b), .ROW_ID(row_b), .PHASE_NUM(num_b), .PHASE_ACTIVE(act_b));
  nbs_asserts #(.PHASE_LEN(PL)) i_nbs_asserts (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .arg_we(lnk.arg_we), .req_we(lnk.req_we), .wdata(lnk.wdata), .arg_rdata(lnk.arg_rdata),
    .param_data(lnk.param_data), .busy(lnk.busy), .phase_irq(lnk.phase_irq));
  initial forever #4 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) if (lnk.phase_irq === 1'b1) irqs++;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge CORE_CLK);
    ADDR <= a;
    WDATA <= v;
    WR <= 1'b1;
    @(posedge CORE_CLK);
    WR <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] exp);
    @(posedge CORE_CLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge CORE_CLK);
    RD <= 1'b0;
    #1 chk(RDATA, exp);
  endtask
  // the stand-in caller shows the inverse word once its request is over
  task automatic call(input logic [15:0] op, input logic [31:0] prm, input logic [31:0] exp);
    @(posedge CORE_CLK);
    lnk_b.wdata <= SRAM_PARAM_ADDR;
    lnk_b.param_data <= prm;
    lnk_b.arg_we <= 1'b1;
    @(posedge CORE_CLK);
    lnk_b.arg_we <= 1'b0;
    lnk_b.req_we <= 1'b1;
    lnk_b.wdata <= {16'h8000, op};
    @(posedge CORE_CLK);
    lnk_b.req_we <= 1'b0;
    lnk_b.param_data <= ~prm;
    #1 chk(lnk_b.arg_rdata, exp);
  endtask
  task automatic wt;
    for (int i = 0; i < 400 && IRQ !== 1'b1; i++) @(posedge CORE_CLK) #1;
  endtask
  initial begin
    repeat (5000) @(posedge CORE_CLK);
    errors++;
    test_done;
  end
  initial begin
    lnk_b.arg_we = 1'b0;
    lnk_b.req_we = 1'b0;
    lnk_b.arg_re = 1'b0;
    lnk_b.wdata = 32'h0;
    lnk_b.param_data = 32'h0;
    repeat (10) @(posedge CORE_CLK);
    NRST <= 1'b1;
    wr(HA_IRQ_MASK, 32'h1);
    wr(HA_PARAM, 32'h0005_0000);
    wr(HA_CMD, 32'h1);
    wr(HA_CMD, 32'h0);
    wt;
    chk(IRQ, 1'b1);
    wr(HA_IRQ_MASK, 32'h0);
    #1 chk(IRQ, 1'b0);
    wr(HA_IRQ_MASK, 32'h1);
    rd(HA_IRQ_STAT, 32'h3);
    chk(IRQ, 1'b0);
    rd(HA_RESULT, ST_OK);
    chk(irqs, 32'h1);
    chk(ROW_ID, 16'h5);
    chk(phase_num, 2'h0);
    rd(4'hF, 32'h0);
    wr(HA_PARAM, 32'h00C8_0000);
    wr(HA_CMD, 32'h0);
    rd(HA_STATUS, 32'hD);
    rd(HA_PARAM, 32'h00C8_0000);
    wt;
    rd(HA_RESULT, ST_OK);
    chk(irqs, 32'h4);
    chk(ROW_ID, 16'hC8);
    chk(phase_num, 2'h2);
    call(OP_PROG_ROW, {16'h3, KEY2_WRITE, KEY1}, ST_KEY_MISMATCH);
    call(OP_PROG_ROW, {16'h3, KEY2_PROG, KEY1}, ST_OK);
    chk(row_b, 16'h3);
    chk(act_b, 1'b1);
    chk(num_b, 2'h0);
    call(OP_WRITE_ROW, {16'h3, KEY2_WRITE, KEY1}, ST_PENDING);
    call(OP_RESUME, {16'hFFFF, KEY2_RESUME, KEY1}, ST_BUSY);
    for (int i = 0; i < 40 && lnk_b.phase_irq !== 1'b1; i++) @(posedge CORE_CLK) #1;
    chk(lnk_b.phase_irq, 1'b1);
    chk(act_b, 1'b0);
    chk(lnk_b.busy, 1'b1);
    call(OP_RESUME, {16'hFFFF, KEY2_RESUME, KEY1}, ST_OK);
    chk(lnk_b.busy, 1'b0);
    call(OP_RESUME, {16'h0, KEY2_RESUME, KEY1}, ST_RESUME_DONE);
    test_done;
  end
endmodule
